// *** logic/qei_pkg.sv ***
// package for the quadrature encoder interface: register map, fields, constants
package qei_pkg;
    // register byte offsets
    localparam logic [3:0] QEI_OFF_CTRL = 4'h0;
    localparam logic [3:0] QEI_OFF_FILT = 4'h4;
    localparam logic [3:0] QEI_OFF_POS = 4'h8;
    localparam logic [3:0] QEI_OFF_MAX = 4'hC;
    // encoder_control field positions
    localparam int QEI_B_ERR = 15;
    localparam int QEI_B_IDX = 12;
    localparam int QEI_B_DIR = 11;
    localparam int QEI_B_MODE = 8;
    localparam int QEI_B_SWAP = 7;
    localparam int QEI_B_GATE = 5;
    localparam int QEI_B_PS = 3;
    localparam int QEI_B_INDEX_RESET_ENABLE = 2;
    localparam int QEI_B_TCS = 1;
    localparam int QEI_B_DSRC = 0;
    // encoder_filter_control field positions
    localparam int QEI_B_IMV = 9;
    localparam int QEI_B_COUNT_ERROR_IRQ_DISABLE = 8;
    localparam int QEI_B_FOE = 7;
    localparam int QEI_B_FCK = 4;
    // reset values
    localparam logic [15:0] QEI_CTRL_RST = 16'h0000;
    localparam logic [15:0] QEI_FILT_RST = 16'h0000;
    localparam logic [15:0] QEI_MAX_RST = 16'hFFFF;
    // filter needs this many equal samples
    localparam int QEI_FILT_LEN = 3;
    // operating modes
    typedef enum logic [2:0] {
        QEI_M_OFF = 3'b000,
        QEI_M_TMR = 3'b001,
        QEI_M_UN2 = 3'b010,
        QEI_M_UN3 = 3'b011,
        QEI_M_X2I = 3'b100,
        QEI_M_X2M = 3'b101,
        QEI_M_X4I = 3'b110,
        QEI_M_X4M = 3'b111
    } qei_mode_e;
    // encoder pins grouped
    typedef struct packed {
        logic idx;
        logic b;
        logic a;
    } qei_pins_s;
endpackage

// *** logic/qei_filter.sv ***
// digital noise filter for one encoder input
`timescale 1ns/10ps
module qei_filter
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic enable,
    input wire logic din,
    output logic dout
);
    import qei_pkg::*;
    logic [QEI_FILT_LEN-1:0] hist_r;
    logic filt_r;

    // shift in a sample on each filter tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hist_r <= '0;
        else if (tick)
            hist_r <= {hist_r[QEI_FILT_LEN-2:0], din};
    end

    // output changes only after a run of equal samples
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            filt_r <= 1'b0;
        else if (&hist_r)
            filt_r <= 1'b1;
        else if (~|hist_r)
            filt_r <= 1'b0;
    end

    // bypass when filtering is off
    assign dout = enable ? filt_r : din;
endmodule

// *** logic/qei_top.sv ***
// quadrature encoder interface with timer mode and axi4-lite registers
// Notes on behaviour
// - 16-bit position counter counts up or down from phases A, B and index
// - mode 111: x4 decode, counter resets on maximum count match
// - mode 110: x4 decode, counter resets on index pulse
// - mode 101: x2 decode, counter resets on maximum count match
// - mode 100: x2 decode, counter resets on index pulse
// - modes 011 and 010 leave the module disabled
// - mode 001 runs the counter as a general 16-bit timer
// - mode 000 turns off both decoder and timer
// - index resets counter only with index reset enable, modes 100/110
// - phase swap exchanges A and B before decoding
// - direction bit writable in timer mode, reports decoded direction otherwise
// - timer mode: direction from phase B pin or software bit
// - direction source bit ignored in quadrature modes
// - gate enable: timer accumulates only while gate input is high
// - timer prescale 1:1, 1:8, 1:64, 1:256
// - timer clock source: phase A rising edges or internal clock
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
module qei_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire qei_pkg::qei_pins_s enc_pins,
    input wire logic gate_in,
    output logic count_error_irq,
    output logic count_dir
);
    import qei_pkg::*;

    // ==================================================================
    // register state
    logic [15:0] ctrl_r;
    logic [15:0] filt_r;
    logic [15:0] maximum_count_value_r;
    logic [15:0] pos_r;
    logic err_r;
    logic dir_r;
    qei_mode_e mode;
    logic quad_mode;
    logic idx_mode;
    logic x4_mode;
    logic tmr_mode;

    assign mode = qei_mode_e'(ctrl_r[QEI_B_MODE+:3]);
    assign quad_mode = ctrl_r[QEI_B_MODE+2];
    assign x4_mode = quad_mode && ctrl_r[QEI_B_MODE+1];
    assign idx_mode = quad_mode && !ctrl_r[QEI_B_MODE];
    assign tmr_mode = (mode == QEI_M_TMR);

    // ==================================================================
    // input synchronisers
    qei_pins_s sync1_r;
    qei_pins_s sync2_r;
    logic gate1_r;
    logic gate2_r;

    // two flops on every pin before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            gate1_r <= 1'b0;
            gate2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= enc_pins;
            sync2_r <= sync1_r;
            gate1_r <= gate_in;
            gate2_r <= gate1_r;
        end
    end

    // ==================================================================
    // noise filters
    logic [7:0] fdiv_r;
    logic ftick;
    logic [2:0] fck;
    logic [3:0] fexp;
    qei_pins_s fpins;

    // filter sample divider
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fdiv_r <= '0;
        else
            fdiv_r <= fdiv_r + 8'h01;
    end

    // tick every 2^exp clocks; codes above 010 skip the 1:8 step
    assign fck = filt_r[QEI_B_FCK+:3];
    assign fexp = (fck > 3'd2) ? {1'b0, fck} + 4'h1 : {1'b0, fck};
    assign ftick = ((9'(fdiv_r) & ((9'h001 << fexp) - 9'h001)) == 9'h000);

    qei_filter u_filt_a (.aclk(aclk), .aresetn(aresetn), .tick(ftick),
        .enable(filt_r[QEI_B_FOE]), .din(sync2_r.a), .dout(fpins.a));
    qei_filter u_filt_b (.aclk(aclk), .aresetn(aresetn), .tick(ftick),
        .enable(filt_r[QEI_B_FOE]), .din(sync2_r.b), .dout(fpins.b));
    qei_filter u_filt_i (.aclk(aclk), .aresetn(aresetn), .tick(ftick),
        .enable(filt_r[QEI_B_FOE]), .din(sync2_r.idx), .dout(fpins.idx));

    // ==================================================================
    // quadrature decode
    logic pa;
    logic pb;
    logic pa_q_r;
    logic pb_q_r;
    logic idx_q_r;
    logic step;
    logic step_dir;
    logic idx_rise;
    logic idx_match;

    assign pa = ctrl_r[QEI_B_SWAP] ? fpins.b : fpins.a;
    assign pb = ctrl_r[QEI_B_SWAP] ? fpins.a : fpins.b;

    // previous phase states
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pa_q_r <= 1'b0;
            pb_q_r <= 1'b0;
            idx_q_r <= 1'b0;
        end
        else
        begin
            pa_q_r <= pa;
            pb_q_r <= pb;
            idx_q_r <= fpins.idx;
        end
    end

    // x4 counts every edge, x2 only phase A edges
    assign step = quad_mode && ((pa ^ pa_q_r) || (x4_mode && (pb ^ pb_q_r)));
    assign step_dir = (pa ^ pa_q_r) ? (pa ^ pb) : !(pa ^ pb);
    assign idx_rise = fpins.idx && !idx_q_r;

    // index phase qualification
    always_comb
    begin
        if (x4_mode)
            idx_match = (pb == filt_r[QEI_B_IMV+1]) && (pa == filt_r[QEI_B_IMV]);
        else
            idx_match = ((filt_r[QEI_B_IMV+1] ? pb : pa) == filt_r[QEI_B_IMV]);
    end

    logic idx_reset;
    assign idx_reset = idx_mode && ctrl_r[QEI_B_INDEX_RESET_ENABLE] && idx_rise && idx_match;

    // ==================================================================
    // timer clocking
    logic [7:0] pre_r;
    logic [7:0] pre_lim;
    logic tclk_evt;
    logic tmr_tick;
    logic tmr_up;

    // prescale limit per code
    always_comb
    begin
        unique case (ctrl_r[QEI_B_PS+:2])
            2'b00: pre_lim = 8'h00;
            2'b01: pre_lim = 8'h07;
            2'b10: pre_lim = 8'h3F;
            2'b11: pre_lim = 8'hFF;
        endcase
    end

    assign tclk_evt = ctrl_r[QEI_B_TCS] ? (pa && !pa_q_r) : 1'b1;
    assign tmr_up = ctrl_r[QEI_B_DSRC] ? pb : dir_r;

    // prescaler counter, held while gated off
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !tmr_mode)
            pre_r <= '0;
        else if (tclk_evt && (!ctrl_r[QEI_B_GATE] || gate2_r))
            pre_r <= (pre_r >= pre_lim) ? 8'h00 : pre_r + 8'h01;
    end

    // at or above the limit: a smaller prescale set mid-count never strands the counter
    assign tmr_tick = tmr_mode && tclk_evt && (!ctrl_r[QEI_B_GATE] || gate2_r)
        && (pre_r >= pre_lim);

    // ==================================================================
    // axi4-lite slave
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_do;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

    // latch address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // merge byte lanes into a 16-bit register
    function automatic logic [15:0] qei_merge(input logic [15:0] old, input logic [31:0] d,
        input logic [3:0] s);
        qei_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic wr_ctrl;
    logic wr_pos;
    logic [15:0] ctrl_w;
    assign wr_ctrl = wr_do && (awaddr_r[3:2] == QEI_OFF_CTRL[3:2]);
    assign wr_pos = wr_do && (awaddr_r[3:2] == QEI_OFF_POS[3:2]);
    assign ctrl_w = qei_merge(ctrl_r, wdata_r, wstrb_r);

    // control, filter and maximum count registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= QEI_CTRL_RST;
            filt_r <= QEI_FILT_RST;
            maximum_count_value_r <= QEI_MAX_RST;
        end
        else if (wr_do)
        begin
            if (wr_ctrl)
                ctrl_r <= ctrl_w;
            if (awaddr_r[3:2] == QEI_OFF_FILT[3:2])
                filt_r <= qei_merge(filt_r, wdata_r, wstrb_r) & 16'h07F0;
            if (awaddr_r[3:2] == QEI_OFF_MAX[3:2])
                maximum_count_value_r <= qei_merge(maximum_count_value_r, wdata_r, wstrb_r);
        end
    end

    // direction: software in timer mode, decoded otherwise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dir_r <= 1'b0;
        else if (quad_mode && step)
            dir_r <= step_dir;
        else if (tmr_mode && wr_ctrl)
            dir_r <= ctrl_w[QEI_B_DIR];
    end

    // position counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pos_r <= '0;
        else if (wr_pos)
            pos_r <= qei_merge(pos_r, wdata_r, wstrb_r);
        else if (idx_reset)
            pos_r <= '0;
        else if (step)
        begin
            if (!idx_mode && step_dir && pos_r == maximum_count_value_r)
                pos_r <= '0;
            else if (!idx_mode && !step_dir && pos_r == 16'h0000)
                pos_r <= maximum_count_value_r;
            else
                pos_r <= step_dir ? pos_r + 16'h0001 : pos_r - 16'h0001;
        end
        else if (tmr_tick)
            pos_r <= tmr_up ? pos_r + 16'h0001 : pos_r - 16'h0001;
    end

    // count error: wrap in index mode without index; set wins over clear
    logic err_evt;
    assign err_evt = idx_mode && step && !idx_reset &&
        ((step_dir && pos_r == 16'hFFFF) || (!step_dir && pos_r == 16'h0000));
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            err_r <= 1'b0;
        else if (err_evt)
            err_r <= 1'b1;
        else if (wr_ctrl && !ctrl_w[QEI_B_ERR])
            err_r <= 1'b0;
    end

    assign count_error_irq = err_r && !filt_r[QEI_B_COUNT_ERROR_IRQ_DISABLE];
    assign count_dir = dir_r;

    // read channel
    logic [15:0] ctrl_rd;
    always_comb
    begin
        ctrl_rd = ctrl_r & 16'h27BF;
        ctrl_rd[QEI_B_ERR] = err_r;
        ctrl_rd[QEI_B_IDX] = fpins.idx;
        ctrl_rd[QEI_B_DIR] = dir_r;
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr[3:2])
                QEI_OFF_CTRL[3:2]: s_axi_rdata <= {16'h0000, ctrl_rd};
                QEI_OFF_FILT[3:2]: s_axi_rdata <= {16'h0000, filt_r};
                QEI_OFF_POS[3:2]: s_axi_rdata <= {16'h0000, pos_r};
                QEI_OFF_MAX[3:2]: s_axi_rdata <= {16'h0000, maximum_count_value_r};
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ==================================================================
    // assertions
    a_idx_clears_pos: assert property (@(posedge aclk) disable iff (!aresetn)
        (idx_reset && !wr_pos) |=> pos_r == 16'h0000)
        else $error("index reset did not clear position");
    a_off_holds_pos: assert property (@(posedge aclk) disable iff (!aresetn)
        (!quad_mode && !tmr_mode && !wr_pos) |=> $stable(pos_r))
        else $error("position moved while module off");
    a_max_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
        (quad_mode && !idx_mode && step && step_dir && pos_r == maximum_count_value_r && !wr_pos)
        |=> pos_r == 16'h0000)
        else $error("max count match did not reset");
    a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        err_evt |=> err_r)
        else $error("count error flag not set");
    a_irq_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        filt_r[QEI_B_COUNT_ERROR_IRQ_DISABLE] |-> !count_error_irq)
        else $error("count error irq not suppressed");
    a_swap_pins: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r[QEI_B_SWAP] |-> (pa == fpins.b && pb == fpins.a))
        else $error("phase swap not applied");
    a_gate_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        (tmr_mode && ctrl_r[QEI_B_GATE] && !gate2_r) |-> !tmr_tick)
        else $error("timer counted while gated");
    a_presc_one: assert property (@(posedge aclk) disable iff (!aresetn)
        (tmr_mode && ctrl_r[QEI_B_PS+:2] == 2'b00 && !ctrl_r[QEI_B_TCS]
        && (!ctrl_r[QEI_B_GATE] || gate2_r))
        |-> tmr_tick)
        else $error("1:1 prescale missed a tick");
    a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

// *** verification/qei_enc_model.sv ***
// partner model of an incremental encoder: quadrature phases, index and pulses
`timescale 1ns/10ps
module qei_enc_model
(
    input wire logic aclk,
    output qei_pkg::qei_pins_s pins
);
    import qei_pkg::*;
    // ============================================================
    // pin state
    localparam int HOLD = 40;
    logic [1:0] ph_r;
    // encoder at rest: both phases low, no index
    initial
    begin
        pins = '0;
        ph_r = 2'b00;
    end
    // ============================================================
    // motion tasks, entered just after a rising edge
    // wait a number of clock edges
    task automatic hold(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // one quarter step; b,a run 00,01,11,10 when moving up
    task automatic step(input logic up);
        begin
            ph_r = up ? ph_r + 2'd1 : ph_r - 2'd1;
            pins.b <= ph_r[1];
            pins.a <= ph_r[1] ^ ph_r[0];
            hold(HOLD);
        end
    endtask
    // high pulse on one pin (0 phase a, 2 index), then rest
    task automatic pulse(input int sel, input int width);
        begin
            pins[sel] <= 1'b1;
            hold(width);
            pins[sel] <= 1'b0;
            hold(HOLD);
        end
    endtask
    // static level on phase b for direction from pin
    task automatic set_b(input logic v);
        begin
            pins.b <= v;
            hold(HOLD);
        end
    endtask
endmodule

// *** verification/qei_top_test.sv ***
// self-checking bench for the quadrature encoder interface
`timescale 1ns/10ps
module qei_top_test;
    import qei_pkg::*;
    // ============================================================
    // signals
    typedef struct packed {logic [15:0] exp; logic [15:0] mask;} qei_note_s;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, gate_in, irq, dir;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    qei_pins_s pins;
    qei_note_s notes[$];
    qei_note_s cur;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int ix_m[6] = '{6, 6, 6, 4, 4, 4};
    int ix_r[6] = '{1, 0, 1, 1, 1, 1};
    int ix_v[6] = '{0, 0, 1, 1, 2, 3};
    logic [15:0] ix_e[6] = '{16'h0000, 16'h0005, 16'h0005, 16'h0005, 16'h0000, 16'h0005};
    int tm_p[6] = '{0, 0, 0, 1, 2, 3};
    int tm_d[6] = '{1, 0, 0, 1, 1, 1};
    int tm_s[6] = '{0, 0, 1, 0, 0, 0};
    int tm_n[6] = '{3, 2, 2, 16, 64, 256};
    logic [15:0] tm_e[6] = '{16'h0003, 16'hFFFE, 16'h0002, 16'h0002, 16'h0001, 16'h0001};
    // ============================================================
    // design and encoder
    qei_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .enc_pins(pins), .gate_in(gate_in), .count_error_irq(irq), .count_dir(dir));
    qei_enc_model u_enc (.aclk(aclk), .pins(pins));
    // ============================================================
    // clock, timeout and checking
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        begin
            total_checks++;
            if (seen !== exp)
            begin
                errors++;
                $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
            end
        end
    endtask
    // counts, verdict and stop
    task automatic end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // read data against the oldest note
    always @(posedge aclk)
    begin
        cyc++;
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            cur = notes.pop_front();
            check(rdata[15:0] & cur.mask, cur.exp & cur.mask, "register read");
            check({14'h0000, rresp}, 16'h0000, "read response");
        end
        if (cyc == 60000)
        begin
            errors++;
            $display("wrong value at %0t: bench timed out", $time);
            end_sim();
        end
    end
    // ============================================================
    // register bus tasks
    function automatic logic [15:0] md(input logic [2:0] m, input int x);
        return 16'(x) | (16'(m) << QEI_B_MODE);
    endfunction
    // one write; each channel released once taken
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        begin
            awaddr <= a;
            wdata <= {16'h0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bready && bvalid)
                begin
                    check({14'h0000, bresp}, 16'h0000, "write response");
                    bready <= 1'b0;
                end
            end
            while (awvalid || wvalid || bready);
        end
    endtask
    // one read; expected value noted first
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        begin
            notes.push_back({e, m});
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rready && rvalid) rready <= 1'b0;
            end
            while (arvalid || rready);
        end
    endtask
    // ============================================================
    // main sequence
    initial
    begin : main
        int i;
        int n;
        logic [15:0] p;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, gate_in} = '0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h00000000;
        wstrb = 4'h3;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        void'($urandom(86));
        rd(QEI_OFF_CTRL, QEI_CTRL_RST, 16'hFFFF);
        rd(QEI_OFF_FILT, QEI_FILT_RST, 16'hFFFF);
        rd(QEI_OFF_POS, 16'h0000, 16'hFFFF);
        rd(QEI_OFF_MAX, QEI_MAX_RST, 16'hFFFF);
        $display("test reset values done");
        n = 1 + $urandom % 6;
        wr(QEI_OFF_MAX, 16'h0003);
        wr(QEI_OFF_CTRL, md(QEI_M_X4M, 0));
        repeat (n) u_enc.step(1'b1);
        rd(QEI_OFF_POS, 16'(n % 4), 16'hFFFF);
        rd(QEI_OFF_CTRL, 16'h0800, 16'h0800);
        check({15'h0000, dir}, 16'h0001, "direction up");
        repeat (n) u_enc.step(1'b0);
        rd(QEI_OFF_POS, 16'h0000, 16'hFFFF);
        check({15'h0000, dir}, 16'h0000, "direction down");
        $display("test x4 match reset done");
        wr(QEI_OFF_MAX, 16'h0005);
        wr(QEI_OFF_CTRL, md(QEI_M_X2M, 0));
        repeat (4) u_enc.step(1'b0);
        rd(QEI_OFF_POS, 16'h0004, 16'hFFFF);
        repeat (4) u_enc.step(1'b1);
        rd(QEI_OFF_POS, 16'h0000, 16'hFFFF);
        $display("test x2 match reset done");
        p = 16'($urandom);
        wr(QEI_OFF_MAX, 16'hFFFF);
        wr(QEI_OFF_CTRL, md(QEI_M_X4M, (1 << QEI_B_SWAP) | (1 << QEI_B_DSRC)));
        wr(QEI_OFF_POS, p);
        repeat (2) u_enc.step(1'b1);
        rd(QEI_OFF_POS, p - 16'h0002, 16'hFFFF);
        repeat (2) u_enc.step(1'b0);
        rd(QEI_OFF_POS, p, 16'hFFFF);
        $display("test phase swap done");
        foreach (ix_m[i])
        begin
            wr(QEI_OFF_CTRL, md(3'(i % 3 == 0 ? 0 : i % 3 + 1), 0));
            wr(QEI_OFF_POS, 16'h0007);
            repeat (4) u_enc.step(1'b1);
            if (i < 3) rd(QEI_OFF_POS, 16'h0007, 16'hFFFF);
            wr(QEI_OFF_FILT, 16'(ix_v[i] << QEI_B_IMV));
            wr(QEI_OFF_CTRL, md(3'(ix_m[i]), ix_r[i] << QEI_B_INDEX_RESET_ENABLE));
            wr(QEI_OFF_POS, 16'h0005);
            u_enc.pulse(2, 40);
            rd(QEI_OFF_POS, ix_e[i], 16'hFFFF);
        end
        $display("test disabled modes and index reset done");
        wr(QEI_OFF_FILT, 16'h0000);
        wr(QEI_OFF_CTRL, md(QEI_M_X4I, 1 << QEI_B_INDEX_RESET_ENABLE));
        wr(QEI_OFF_POS, 16'h0000);
        repeat (4) u_enc.step(1'b0);
        rd(QEI_OFF_CTRL, 16'h8000, 16'h8000);
        check({15'h0000, irq}, 16'h0001, "error interrupt");
        wr(QEI_OFF_FILT, 16'(1 << QEI_B_COUNT_ERROR_IRQ_DISABLE));
        repeat (2) @(posedge aclk);
        check({15'h0000, irq}, 16'h0000, "masked interrupt");
        wr(QEI_OFF_CTRL, md(QEI_M_X4I, 1 << QEI_B_INDEX_RESET_ENABLE));
        rd(QEI_OFF_CTRL, 16'h0000, 16'h8000);
        $display("test count error done");
        foreach (tm_p[i])
        begin
            u_enc.set_b(1'(tm_s[i]));
            // direction bit only takes once timer mode is on, so write twice
            repeat (2) wr(QEI_OFF_CTRL, md(QEI_M_TMR, (tm_d[i] << QEI_B_DIR)
                | (tm_p[i] << QEI_B_PS) | (1 << QEI_B_TCS) | (tm_s[i] << QEI_B_DSRC)));
            wr(QEI_OFF_POS, 16'h0000);
            repeat (tm_n[i]) u_enc.pulse(0, 40);
            rd(QEI_OFF_POS, tm_e[i], 16'hFFFF);
        end
        u_enc.set_b(1'b0);
        $display("test timer external clock done");
        wr(QEI_OFF_CTRL, md(QEI_M_TMR, (1 << QEI_B_DIR) | (1 << QEI_B_TCS)));
        wr(QEI_OFF_POS, 16'h0000);
        u_enc.pulse(0, 4);
        rd(QEI_OFF_POS, 16'h0001, 16'hFFFF);
        wr(QEI_OFF_FILT, 16'((1 << QEI_B_FOE) | (2 << QEI_B_FCK)));
        u_enc.pulse(0, 4);
        rd(QEI_OFF_POS, 16'h0001, 16'hFFFF);
        u_enc.pulse(0, 40);
        rd(QEI_OFF_POS, 16'h0002, 16'hFFFF);
        $display("test noise filter done");
        wr(QEI_OFF_FILT, 16'h0000);
        wr(QEI_OFF_CTRL, md(QEI_M_TMR, (1 << QEI_B_DIR) | (1 << QEI_B_GATE)));
        wr(QEI_OFF_POS, 16'h1234);
        repeat (20) @(posedge aclk);
        rd(QEI_OFF_POS, 16'h1234, 16'hFFFF);
        // ten cycles of open gate give ten ticks; sync delay cancels at both ends
        gate_in <= 1'b1;
        repeat (10) @(posedge aclk);
        gate_in <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(QEI_OFF_POS, 16'h123E, 16'hFFFF);
        $display("test timer gate done");
        // one byte lane at a time; upper strobes are ignored
        wstrb <= 4'h9;
        wr(QEI_OFF_POS, 16'h00AB);
        wstrb <= 4'h6;
        wr(QEI_OFF_POS, 16'h5600);
        rd(QEI_OFF_POS, 16'h56AB, 16'hFFFF);
        $display("test byte lanes done");
        repeat (4) @(posedge aclk);
        end_sim();
    end
endmodule
